// >>> nic_map.svh
// register offsets, field positions, codes and reset values of the interrupt controller
// assumes inclusion by bare name from the package and the design module
`ifndef NIC_MAP_SVH
`define NIC_MAP_SVH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define NIC_SOFT_LVL0_OFF   8'h00
`define NIC_SOFT_LVL1_OFF   8'h04
`define NIC_SOFT_LVL2_OFF   8'h08
`define NIC_SOFT_LVL3_OFF   8'h0C
`define NIC_EXT_SENSE_OFF   8'h10
`define NIC_PIN_SEL_OFF     8'h14
`define NIC_SRC_EN_OFF      8'h18
`define NIC_STATUS_OFF      8'h1C

// ----------------------------------------------------------------------------
// sizes, fields and codes
// ----------------------------------------------------------------------------
`define NIC_NUM_SRC         14
`define NIC_NUM_LINES       3
`define NIC_PINS_PER_LINE   4
`define NIC_FIRST_EXT       2
`define NIC_ESTOP_POL_BIT   6
`define NIC_ST_LEVEL_LSB    16
`define NIC_ST_BUSY_BIT     18
`define NIC_LEVEL0          2'h2
`define NIC_LEVEL1          2'h1
`define NIC_LEVEL2          2'h0
`define NIC_LEVEL3          2'h3
`define NIC_SENSE_LEVEL     2'h0
`define NIC_SENSE_RISE      2'h1
`define NIC_SENSE_FALL      2'h2
`define NIC_SENSE_BOTH      2'h3
`define NIC_VEC_ESTOP       4'h0
`define NIC_VEC_TRAP        4'hE
`define NIC_VEC_RESET       4'hF
`define NIC_ADDR_BASE       16'hFFFA
`define NIC_ADDR_TRAP       16'hFFFC
`define NIC_ADDR_RESET      16'hFFFE

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define NIC_SOFT_LVL_RST    32'hFFFFFFFF
`define NIC_LOCKED_BITS     4'hF
`define NIC_WAKE_MASK_RST   14'h011E

`endif

// >>> nic_pkg.sv
// types of the nested interrupt controller
// assumes nic_map.svh beside it
package nic_pkg;
`include "nic_map.svh"

  typedef enum logic [0:0] {
    NIC_IDLE  = 1'b0,
    NIC_OFFER = 1'b1
  } nic_svc_t;

  typedef struct packed {
    logic [31:0]     soft_lvl;
    logic [6:0]      sense;
    logic [11:0]     pin_sel;
    logic [13:0]     src_en;
    logic [1:0]      cur_level;
    logic [2:0]      line_prev;
    logic [2:0]      ext_latch;
    logic            estop_latch;
    logic            estop_prev;
    logic            trap_pend;
    logic            rst_pend;
    nic_svc_t        svc;
    logic [3:0]      vec;
    logic [15:0]     addr;
    logic [1:0]      new_level;
    logic            stack;
    logic            wr_pend;
    logic [7:0]      wr_addr;
    logic [31:0]     rdata;
  } nic_state_t;
endpackage : nic_pkg

// >>> nested_interrupt_controller.sv
// nested priority interrupt controller with an ahb-lite register slave
// assumes a cpu sequencer that stacks, fetches vectors and acknowledges service
`timescale 1ns/1ps
`include "nic_map.svh"

module nested_interrupt_controller #(
  parameter int          NUM_SRC   = `NIC_NUM_SRC,
  parameter logic [13:0] WAKE_MASK = `NIC_WAKE_MASK_RST
) (
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic [11:0] ext_pin,
  input  wire logic        estop_pin,
  input  wire logic        speed_err,
  input  wire logic [13:0] periph_flag,
  input  wire logic        instr_boundary,
  input  wire logic        trap_exec,
  input  wire logic        in_wait,
  input  wire logic        in_halt,
  input  wire logic        cpu_level_we,
  input  wire logic [1:0]  cpu_level_in,
  input  wire logic        irq_ack,
  output logic             irq_req,
  output logic [3:0]       irq_vec,
  output logic [15:0]      irq_addr,
  output logic [1:0]       irq_level,
  output logic             irq_stack,
  output logic [1:0]       cur_level,
  output logic             wake
);

  // --------------------------------------------------------------------------
  // elaboration checks
  // --------------------------------------------------------------------------
  if (NUM_SRC != `NIC_NUM_SRC) begin : g_bad_src
    $error("NUM_SRC must equal the fixed source count");
  end

  // --------------------------------------------------------------------------
  // functions
  // --------------------------------------------------------------------------
  // level code to nesting rank, 0 lowest
  function automatic logic [1:0] nic_rank(input logic [1:0] code);
    case (code)
      `NIC_LEVEL0: nic_rank = 2'h0;
      `NIC_LEVEL1: nic_rank = 2'h1;
      `NIC_LEVEL2: nic_rank = 2'h2;
      default:     nic_rank = 2'h3;
    endcase
  endfunction : nic_rank

  // per-field merge; the main-level code is refused so no vector can sit below main
  function automatic logic [7:0] nic_merge(input logic [7:0] old_v, input logic [7:0] new_v);
    nic_merge = old_v;
    for (int f = 0; f < 4; f++) begin
      if (new_v[2*f+:2] != `NIC_LEVEL0) begin
        nic_merge[2*f+:2] = new_v[2*f+:2];
      end
    end
  endfunction : nic_merge

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  localparam nic_pkg::nic_state_t RST_STATE = '{
    soft_lvl:    `NIC_SOFT_LVL_RST,
    sense:       7'h00,
    pin_sel:     12'h000,
    src_en:      14'h0000,
    cur_level:   `NIC_LEVEL3,
    line_prev:   3'h0,
    ext_latch:   3'h0,
    estop_latch: 1'b0,
    estop_prev:  1'b0,
    trap_pend:   1'b0,
    rst_pend:    1'b1,
    svc:         nic_pkg::NIC_IDLE,
    vec:         4'h0,
    addr:        16'h0000,
    new_level:   `NIC_LEVEL3,
    stack:       1'b0,
    wr_pend:     1'b0,
    wr_addr:     8'h00,
    rdata:       32'h00000000
  };

  nic_pkg::nic_state_t s_q;
  nic_pkg::nic_state_t s_d;
  logic [2:0]          line_val;
  logic [2:0]          ext_set;
  logic [13:0]         pend;
  logic                found;
  logic [2:0]          best;
  logic [3:0]          win;
  logic                cap;
  logic                ack;
  logic                estop_set;

  // --------------------------------------------------------------------------
  // request collection and arbitration
  // --------------------------------------------------------------------------
  always_comb begin
    logic [1:0] mode;
    logic [2:0] eff;
    logic       ok;
    mode  = 2'h0;
    eff   = 3'h0;
    ok    = 1'b0;
    found = 1'b0;
    best  = 3'h0;
    win   = 4'h0;
    for (int i = 0; i < `NIC_NUM_SRC; i++) begin
      pend[i] = s_q.src_en[i] & periph_flag[i];
    end
    estop_set = (s_q.sense[`NIC_ESTOP_POL_BIT] ? (estop_pin & ~s_q.estop_prev)
                                               : (~estop_pin & s_q.estop_prev))
                | speed_err;
    pend[0] = s_q.src_en[0] & s_q.estop_latch;
    for (int g = 0; g < `NIC_NUM_LINES; g++) begin
      line_val[g] = |(ext_pin[g*`NIC_PINS_PER_LINE+:`NIC_PINS_PER_LINE]
                      & s_q.pin_sel[g*`NIC_PINS_PER_LINE+:`NIC_PINS_PER_LINE]);
      mode = s_q.sense[2*g+:2];
      ext_set[g] = ((mode == `NIC_SENSE_RISE) && line_val[g] && !s_q.line_prev[g])
                 | ((mode == `NIC_SENSE_FALL) && !line_val[g] && s_q.line_prev[g])
                 | ((mode == `NIC_SENSE_BOTH) && (line_val[g] != s_q.line_prev[g]));
      pend[`NIC_FIRST_EXT+g] = s_q.src_en[`NIC_FIRST_EXT+g]
          & ((mode == `NIC_SENSE_LEVEL) ? line_val[g] : s_q.ext_latch[g]);
    end
    // downward scan with >= lets the lower index win a tie
    for (int i = `NIC_NUM_SRC - 1; i >= 0; i--) begin
      eff = (i == 0) ? 3'h4 : {1'b0, nic_rank(s_q.soft_lvl[2*i+:2])};
      ok  = pend[i] && ((i == 0) || (eff > {1'b0, nic_rank(s_q.cur_level)}))
            && (!in_halt || WAKE_MASK[i]);
      if (ok && (!found || eff >= best)) begin
        found = 1'b1;
        best  = eff;
        win   = 4'(i);
      end
    end
    if (s_q.trap_pend) begin
      found = 1'b1;
      win   = `NIC_VEC_TRAP;
    end
    if (s_q.rst_pend) begin
      found = 1'b1;
      win   = `NIC_VEC_RESET;
    end
  end

  assign cap = (s_q.svc == nic_pkg::NIC_IDLE) && found && instr_boundary;
  assign ack = (s_q.svc == nic_pkg::NIC_OFFER) && irq_ack;

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.line_prev  = line_val;
    s_d.estop_prev = estop_pin;
    // a new event in the acknowledge cycle keeps its latch set
    for (int g = 0; g < `NIC_NUM_LINES; g++) begin
      s_d.ext_latch[g] = ext_set[g] | (s_q.ext_latch[g]
          & !(ack && (s_q.vec == 4'(`NIC_FIRST_EXT + g))));
    end
    s_d.estop_latch = estop_set | (s_q.estop_latch & !(ack && s_q.vec == `NIC_VEC_ESTOP));
    s_d.trap_pend   = trap_exec | (s_q.trap_pend & !(ack && s_q.vec == `NIC_VEC_TRAP));
    s_d.rst_pend    = s_q.rst_pend & !(ack && s_q.vec == `NIC_VEC_RESET);
    // level restored by the cpu on return, rim, sim, halt, wfi and flag pops
    if (ack) begin
      s_d.cur_level = s_q.new_level;
    end else if (cpu_level_we) begin
      s_d.cur_level = cpu_level_in;
    end
    case (s_q.svc)
      nic_pkg::NIC_IDLE: begin
        if (cap) begin
          s_d.svc   = nic_pkg::NIC_OFFER;
          s_d.vec   = win;
          s_d.stack = (win != `NIC_VEC_RESET);
          if (win == `NIC_VEC_RESET) begin
            s_d.addr = `NIC_ADDR_RESET;
          end else if (win == `NIC_VEC_TRAP) begin
            s_d.addr = `NIC_ADDR_TRAP;
          end else begin
            s_d.addr = `NIC_ADDR_BASE - {11'h000, win, 1'b0};
          end
          if (win == `NIC_VEC_ESTOP || win >= `NIC_VEC_TRAP) begin
            s_d.new_level = `NIC_LEVEL3;
          end else begin
            s_d.new_level = s_q.soft_lvl[2*win+:2];
          end
        end
      end
      nic_pkg::NIC_OFFER: begin
        if (irq_ack) begin
          s_d.svc = nic_pkg::NIC_IDLE;
        end
      end
      default: s_d.svc = nic_pkg::NIC_IDLE;
    endcase
    // register write, data phase
    if (s_q.wr_pend) begin
      if (s_q.wr_addr == `NIC_SOFT_LVL0_OFF) begin
        s_d.soft_lvl[7:0] = nic_merge(s_q.soft_lvl[7:0], hwdata[7:0]);
      end else if (s_q.wr_addr == `NIC_SOFT_LVL1_OFF) begin
        s_d.soft_lvl[15:8] = nic_merge(s_q.soft_lvl[15:8], hwdata[7:0]);
      end else if (s_q.wr_addr == `NIC_SOFT_LVL2_OFF) begin
        s_d.soft_lvl[23:16] = nic_merge(s_q.soft_lvl[23:16], hwdata[7:0]);
      end else if (s_q.wr_addr == `NIC_SOFT_LVL3_OFF) begin
        s_d.soft_lvl[27:24] = 4'(nic_merge({4'h0, s_q.soft_lvl[27:24]},
                                           {4'h0, hwdata[3:0]}));
      end else if (s_q.wr_addr == `NIC_EXT_SENSE_OFF) begin
        s_d.sense = hwdata[6:0];
      end else if (s_q.wr_addr == `NIC_PIN_SEL_OFF) begin
        s_d.pin_sel = hwdata[11:0];
      end else if (s_q.wr_addr == `NIC_SRC_EN_OFF) begin
        s_d.src_en = hwdata[13:0];
      end
    end
    // address phase; read data registered here so the data phase needs no wait
    s_d.wr_pend = hsel && htrans[1] && hready && hwrite;
    s_d.wr_addr = haddr[7:0];
    if (hsel && htrans[1] && hready && !hwrite) begin
      if (haddr[7:0] == `NIC_SOFT_LVL0_OFF) begin
        s_d.rdata = {24'h000000, s_q.soft_lvl[7:0]};
      end else if (haddr[7:0] == `NIC_SOFT_LVL1_OFF) begin
        s_d.rdata = {24'h000000, s_q.soft_lvl[15:8]};
      end else if (haddr[7:0] == `NIC_SOFT_LVL2_OFF) begin
        s_d.rdata = {24'h000000, s_q.soft_lvl[23:16]};
      end else if (haddr[7:0] == `NIC_SOFT_LVL3_OFF) begin
        s_d.rdata = {24'h000000, `NIC_LOCKED_BITS, s_q.soft_lvl[27:24]};
      end else if (haddr[7:0] == `NIC_EXT_SENSE_OFF) begin
        s_d.rdata = {25'h0000000, s_q.sense};
      end else if (haddr[7:0] == `NIC_PIN_SEL_OFF) begin
        s_d.rdata = {20'h00000, s_q.pin_sel};
      end else if (haddr[7:0] == `NIC_SRC_EN_OFF) begin
        s_d.rdata = {18'h00000, s_q.src_en};
      end else if (haddr[7:0] == `NIC_STATUS_OFF) begin
        s_d.rdata = {13'h0000, s_q.svc, s_q.cur_level, 2'h0, pend};
      end else begin
        s_d.rdata = 32'h00000000;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      s_q <= RST_STATE;
    end else begin
      s_q <= s_d;
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = s_q.rdata;
  assign irq_req   = (s_q.svc == nic_pkg::NIC_OFFER);
  assign irq_vec   = s_q.vec;
  assign irq_addr  = s_q.addr;
  assign irq_level = s_q.new_level;
  assign irq_stack = s_q.stack;
  assign cur_level = s_q.cur_level;
  // wait ends on any request; halt only on wake-capable ones, a trap or a reset
  assign wake = (in_wait && ((|pend) || s_q.trap_pend || s_q.rst_pend))
              || (in_halt && ((|(pend & WAKE_MASK)) || s_q.trap_pend
                              || s_q.rst_pend));

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  AST_RESET_FIRST: assert property (s_q.rst_pend && cap |=> irq_req && irq_vec == 4'hF
      && irq_level == 2'h3 && !irq_stack && irq_addr == 16'hFFFE)
    else $error("reset service not offered at level 3 without stacking");
  AST_ACK_LEVEL: assert property (irq_req && irq_ack |=> cur_level == $past(irq_level))
    else $error("current level not loaded on acknowledge");
  AST_MASK_LEVEL: assert property (cap && win != 4'h0 && win < 4'hE
      |-> nic_rank(s_q.soft_lvl[2*win+:2]) > nic_rank(s_q.cur_level))
    else $error("maskable source taken at or below current level");
  AST_BOUNDARY: assert property ($rose(irq_req) |-> $past(instr_boundary))
    else $error("service offered outside an instruction boundary");
  AST_TRAP_LEVEL: assert property (irq_req && irq_vec == 4'hE
      |-> irq_level == 2'h3 && irq_stack && irq_addr == 16'hFFFC)
    else $error("trap not offered at level 3 with stacking");
  AST_NO_MAIN_CODE: assert property (s_q.wr_pend && s_q.wr_addr == 8'h00
      && hwdata[1:0] == 2'h2 |=> s_q.soft_lvl[1:0] == $past(s_q.soft_lvl[1:0]))
    else $error("main-level code stored into a priority field");
  AST_EXT_CLEAR: assert property (ack && s_q.vec == 4'h2 && !ext_set[0]
      |=> !s_q.ext_latch[0])
    else $error("edge latch not cleared on handler entry");
  AST_PERIPH_GATE: assert property (cap && win == 4'h5
      |-> periph_flag[5] && s_q.src_en[5])
    else $error("peripheral taken without flag and enable");
  AST_HALT_WAKE: assert property (in_halt && cap && win < 4'hE |-> WAKE_MASK[win])
    else $error("non wake-capable source served first out of halt");
  AST_TRAP_OVER: assert property (cap && s_q.trap_pend && !s_q.rst_pend
      |=> irq_vec == 4'hE)
    else $error("trap lost arbitration to a maskable source");
  AST_ACK_DROP: assert property (irq_req && irq_ack |=> !irq_req [*2]
      or (!irq_req ##1 irq_req))
    else $error("request not withdrawn after acknowledge");

  COV_ESTOP: cover property (cap && win == 4'h0);
  COV_NEST: cover property (irq_req && irq_ack && cur_level != 2'h2 ##[1:20] irq_req);
  COV_HALT_WAKE: cover property (in_halt && wake);
  COV_TRAP: cover property (irq_req && irq_vec == 4'hE);

endmodule : nested_interrupt_controller

// >>> nic_cpu_model.sv
// cpu sequencer model: instruction boundaries, service acknowledge, flag stack
// assumes the controller's service link and one shared clock
`timescale 1ns/1ps

module nic_cpu_model (
  input  wire logic       clock,
  input  wire logic       srst,
  input  wire logic       run,
  input  wire logic       slow,
  input  wire logic       ret,
  input  wire logic       set_we,
  input  wire logic [1:0] set_lvl,
  input  wire logic       irq_req,
  input  wire logic       irq_stack,
  input  wire logic [1:0] cur_level,
  output logic            instr_boundary,
  output logic            irq_ack,
  output logic            cpu_level_we,
  output logic [1:0]      cpu_level_in
);
  logic [1:0] stk_q [8];
  logic [2:0] sp_q;
  logic [1:0] cnt_q;

  // ----------------------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------------------
  // no boundary while stacking: the next instruction has not started
  assign instr_boundary = run & ~irq_ack;
  always_ff @(posedge clock) begin
    cpu_level_we <= 1'b0;
    if (srst) begin
      irq_ack      <= 1'b0;
      sp_q         <= 3'h0;
      cnt_q        <= 2'h0;
      cpu_level_in <= 2'h3;
    end else begin
      if (irq_ack) begin
        irq_ack <= 1'b0;
        cnt_q   <= 2'h0;
        // only the level is pushed as the flags; pc, index and accumulator are not modelled
        if (irq_stack) begin
          stk_q[sp_q] <= cur_level;
          sp_q        <= sp_q + 3'h1;
        end
      end else if (irq_req) begin
        // slow mode stalls the acknowledge to stress the held offer
        if (!slow || cnt_q == 2'h3) begin
          irq_ack <= 1'b1;
        end
        cnt_q <= cnt_q + 2'h1;
      end
      if (set_we) begin
        cpu_level_we <= 1'b1;
        cpu_level_in <= set_lvl;
      end else if (ret) begin
        // return pops the flags: the interrupted level resumes
        cpu_level_we <= 1'b1;
        cpu_level_in <= stk_q[sp_q - 3'h1];
        sp_q         <= sp_q - 3'h1;
      end
    end
  end
endmodule : nic_cpu_model

// >>> test_nested_interrupt_controller.sv
// self-checking bench of the nested interrupt controller
// assumes nic_map.svh and the cpu sequencer model beside it
`timescale 1ns/1ps
`include "nic_map.svh"

module test_nested_interrupt_controller;
  logic        clock, srst, hsel, hwrite, hready, hreadyout, hresp, wake;
  logic        estop_pin, speed_err, trap_exec, in_wait, in_halt, irq_req, irq_stack;
  logic        instr_boundary, irq_ack, cpu_level_we, run, slow, ret, set_we;
  logic [1:0]  htrans, cpu_level_in, irq_level, cur_level, set_lvl, cl;
  logic [2:0]  hsize;
  logic [3:0]  irq_vec;
  logic [11:0] ext_pin;
  logic [13:0] periph_flag, en;
  logic [15:0] irq_addr;
  logic [31:0] haddr, hwdata, hrdata, soft_m, rd;
  int          bad_count, checks, seed, ex;
  assign hready = hreadyout;

  nested_interrupt_controller DUT (
    .clock(clock), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ext_pin(ext_pin),
    .estop_pin(estop_pin), .speed_err(speed_err), .periph_flag(periph_flag),
    .instr_boundary(instr_boundary), .trap_exec(trap_exec), .in_wait(in_wait),
    .in_halt(in_halt), .cpu_level_we(cpu_level_we), .cpu_level_in(cpu_level_in),
    .irq_ack(irq_ack), .irq_req(irq_req), .irq_vec(irq_vec), .irq_addr(irq_addr),
    .irq_level(irq_level), .irq_stack(irq_stack), .cur_level(cur_level), .wake(wake));
  nic_cpu_model cpu (
    .clock(clock), .srst(srst), .run(run), .slow(slow), .ret(ret), .set_we(set_we),
    .set_lvl(set_lvl), .irq_req(irq_req), .irq_stack(irq_stack), .cur_level(cur_level),
    .instr_boundary(instr_boundary), .irq_ack(irq_ack), .cpu_level_we(cpu_level_we),
    .cpu_level_in(cpu_level_in));

  // ----------------------------------------------------------------------------
  // reference and helpers
  // ----------------------------------------------------------------------------
  function automatic int rank(input logic [1:0] c);
    return (c == 2'h2) ? 0 : (c == 2'h1) ? 1 : (c == 2'h0) ? 2 : 3;
  endfunction : rank
  function automatic logic [1:0] fld(input int v);
    return soft_m[2*v+:2];
  endfunction : fld
  // software level first; scanning upward lets the lower index win ties
  function automatic int winner(input logic [13:0] p, input logic [1:0] c);
    int w;
    w = -1;
    for (int v = 0; v < 14; v++) begin
      if (p[v] && rank(fld(v)) > rank(c) && (w < 0 || rank(fld(v)) > rank(fld(w)))) w = v;
    end
    return w;
  endfunction : winner

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic end_sim();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {24'h0, a};
    do @(posedge clock); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic wr_soft(input int k, input logic [7:0] d);
    for (int f = 0; f < 4; f++) begin
      if (d[2*f+:2] != 2'h2) soft_m[8*k+2*f+:2] = d[2*f+:2];
    end
    soft_m[31:28] = 4'hF;
    bus(1'b1, 8'(4 * k), {24'h0, d});
  endtask : wr_soft
  task automatic lvl(input logic [1:0] c);
    @(posedge clock);
    set_we  <= 1'b1;
    set_lvl <= c;
    @(posedge clock);
    set_we <= 1'b0;
    repeat (2) @(posedge clock);
  endtask : lvl
  task automatic pop();
    @(posedge clock);
    ret <= 1'b1;
    @(posedge clock);
    ret <= 1'b0;
    repeat (2) @(posedge clock);
  endtask : pop
  task automatic offer(input int v, input logic [1:0] l, input logic st);
    int n;
    logic [31:0] ea;
    n = 0;
    run <= 1'b1;
    while (irq_req !== 1'b1 && n < 40) begin
      @(posedge clock);
      n++;
    end
    run <= 1'b0;
    chk("irq_req", 32'h1, irq_req);
    chk("irq_vec", v, irq_vec);
    ea = (v == 15) ? 32'hFFFE : (v == 14) ? 32'hFFFC : 32'hFFFA - 32'(2 * v);
    chk("irq_addr", ea, irq_addr);
    chk("irq_level", l, irq_level);
    chk("irq_stack", st, irq_stack);
    while (irq_req !== 1'b0 && n < 40) begin
      @(posedge clock);
      n++;
    end
    chk("irq_drop", 32'h0, irq_req);
    chk("cur_level", l, cur_level);
  endtask : offer
  task automatic none(input int cyc);
    logic seen;
    seen = 1'b0;
    run <= 1'b1;
    repeat (cyc) begin
      @(posedge clock);
      seen = seen | irq_req;
    end
    run <= 1'b0;
    chk("no_offer", 32'h0, seen);
  endtask : none

  // ----------------------------------------------------------------------------
  // stimulus
  // ----------------------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  initial begin
    repeat (20000) @(posedge clock);
    bad_count++;
    end_sim();
  end
  initial begin
    seed = 32'hA2867857;
    {bad_count, checks} = '0;
    {hsel, hwrite, estop_pin, speed_err, trap_exec, in_wait, in_halt} = '0;
    {run, slow, ret, set_we, set_lvl, htrans, haddr, hwdata, ext_pin, periph_flag} = '0;
    hsize = 3'h2;
    soft_m = `NIC_SOFT_LVL_RST;
    srst = 1'b1;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    offer(15, `NIC_LEVEL3, 1'b0);
    for (int k = 0; k < 4; k++) begin
      bus(1'b0, 8'(4 * k), 32'h0);
      chk("soft_rst", 32'hFF, rd);
    end
    wr_soft(0, 8'hCF);
    wr_soft(0, 8'h64);
    bus(1'b0, `NIC_SOFT_LVL0_OFF, 32'h0);
    chk("soft_keep", 32'h44, rd);
    wr_soft(3, 8'h00);
    bus(1'b0, `NIC_SOFT_LVL3_OFF, 32'h0);
    chk("soft3", 32'hF0, rd);
    bus(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h0, rd);
    chk("hresp", 32'h0, hresp);
    for (int t = 0; t < 24; t++) begin
      for (int k = 0; k < 4; k++) wr_soft(k, 8'($random(seed)));
      en = 14'($random(seed)) & 14'h3FE2;
      bus(1'b1, `NIC_SRC_EN_OFF, {18'h0, en});
      cl = 2'($random(seed));
      lvl(cl);
      slow <= 1'($random(seed));
      periph_flag <= 14'($random(seed)) & 14'h3FE2;
      @(posedge clock);
      ex = winner(periph_flag & en, cl);
      if (ex >= 0) offer(ex, fld(ex), 1'b1);
      else none(6);
      periph_flag <= '0;
    end
    wr_soft(1, 8'h47);
    wr_soft(2, 8'hFF);
    bus(1'b1, `NIC_SRC_EN_OFF, 32'h00E0);
    lvl(`NIC_LEVEL0);
    periph_flag <= 14'h0020;
    offer(5, 2'h1, 1'b1);
    periph_flag <= 14'h0040;
    offer(6, 2'h0, 1'b1);
    periph_flag <= 14'h0080;
    none(6);
    pop();
    chk("cur_level", 2'h1, cur_level);
    none(6);
    pop();
    offer(7, 2'h1, 1'b1);
    periph_flag <= 14'h0200;
    bus(1'b1, `NIC_SRC_EN_OFF, 32'h0200);
    lvl(`NIC_LEVEL3);
    none(4);
    bus(1'b0, `NIC_STATUS_OFF, 32'h0);
    chk("status", 32'h00030200, rd);
    periph_flag <= '0;
    lvl(`NIC_LEVEL0);
    none(6);
    bus(1'b1, `NIC_EXT_SENSE_OFF, 32'h41);
    bus(1'b1, `NIC_SRC_EN_OFF, 32'h0205);
    lvl(`NIC_LEVEL3);
    estop_pin <= 1'b1;
    offer(0, `NIC_LEVEL3, 1'b1);
    estop_pin <= 1'b0;
    none(4);
    speed_err <= 1'b1;
    @(posedge clock);
    speed_err <= 1'b0;
    offer(0, `NIC_LEVEL3, 1'b1);
    trap_exec <= 1'b1;
    @(posedge clock);
    trap_exec <= 1'b0;
    offer(14, `NIC_LEVEL3, 1'b1);
    bus(1'b1, `NIC_PIN_SEL_OFF, 32'h005);
    wr_soft(0, 8'h0F);
    lvl(`NIC_LEVEL0);
    ext_pin <= 12'h002;
    none(4);
    ext_pin <= 12'h006;
    offer(2, fld(2), 1'b1);
    lvl(`NIC_LEVEL0);
    none(4);
    ext_pin <= 12'h000;
    periph_flag <= 14'h0200;
    in_halt <= 1'b1;
    repeat (2) @(posedge clock);
    chk("wake_halt", 32'h0, wake);
    in_halt <= 1'b0;
    in_wait <= 1'b1;
    repeat (2) @(posedge clock);
    chk("wake_wait", 32'h1, wake);
    in_wait <= 1'b0;
    in_halt <= 1'b1;
    ext_pin <= 12'h001;
    repeat (2) @(posedge clock);
    chk("wake_halt", 32'h1, wake);
    offer(2, fld(2), 1'b1);
    in_halt <= 1'b0;
    offer(9, fld(9), 1'b1);
    end_sim();
  end
endmodule : test_nested_interrupt_controller
